// ### pkg/mcc_pkg.sv
// Purpose: Constants for the module clock control block
// Assumes: 10 MHz system clock, 2-wire serial slave pins sampled in that domain
// Notes:   Control byte bit positions, bus addresses and PHY register indices
package mcc_pkg;
  localparam logic [6:0] MCC_ADDR_CTRL     = 7'h51;      // A2h as 7-bit address
  localparam logic [7:0] MCC_CTRL_RESET    = 8'hBF;
  localparam int         MCC_BIT_RSVD      = 7;
  localparam int         MCC_BIT_HOST_IF   = 6;
  localparam int         MCC_BIT_LOW_PWR_N = 5;
  localparam int         MCC_BIT_PHY_RST_N = 4;
  localparam int         MCC_BIT_CLK_MODE  = 3;
  localparam int         MCC_BIT_CLK_DIS   = 2;
  localparam int         MCC_BIT_PIN8_LOS  = 1;
  localparam int         MCC_BIT_INT_OSC   = 0;
  localparam logic [7:0] MCC_PHY_GIG_CTRL  = 8'h09;      // phy_gigabit_control
  localparam logic [7:0] MCC_PHY_CR_EN     = 8'h15;      // phy_clock_recovery_enable
  localparam logic [7:0] MCC_PHY_CR_SETUP  = 8'h17;      // phy_clock_recovery_setup
  localparam logic [15:0] MCC_CR_EN_VALUE  = 16'h0010;
  localparam int         MCC_SYNC_STAGES   = 2;
  localparam int         MCC_CLK_MHZ       = 10;
  localparam int         MCC_CLK_NS        = 1000 / MCC_CLK_MHZ;
endpackage

// ### rtl/mcc_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous level
// Assumes: First stage is read only by the second stage
// Notes:   Reset value is a parameter so pulled-up pins idle high
`timescale 1ns/100ps
module mcc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clock,   // System clock
  input  wire logic rst_n,   // Synchronous reset, active low
  input  wire logic d_in,    // Asynchronous level
  output logic      q_out    // Synchronised level
);
  logic meta_q;

  // Plain double flop; no logic taps the metastable stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      q_out  <= RESET_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// ### rtl/mcc_top.sv
// Purpose: Control byte slave at A2h and the pin and PHY control it steers
// Assumes: SCL and SDA are oversampled by the 10 MHz clock (100 kHz bus)
// Notes:   Register address bytes sent to A2h are accepted and discarded
`timescale 1ns/100ps
// Functional notes
// (R1) Control byte powers up as 0xBF.
// (R2) Byte at A2h read/written directly; any register address ignored.
// (R3) Host always writes bit 7 as one.
// (R4) Bit 6 one selects plain gigabit serial mode, zero SGMII.
// (R5) Bit 5 zero enters low power mode.
// (R6) Bit 4 zero asserts PHY reset.
// (R7) Bit 3 one normal clock rates, zero restrict to 25 MHz.
// (R8) Bit 2 zero enables pin 2 clock output.
// (R9) Bit 1 one pin 8 reports LOS, zero PHY interrupt.
// (R10) Bit 0 one internal oscillator, zero external reference clock.
// (R11) Pin 8 low while PHY interrupt pending in interrupt mode.
// (R12) Pin 2 clock only when enabled here and in the PHY.
// (R13) Link down: recovered output carries local 25 MHz clock.
// (R14) Link up: 25 MHz at 1000/100, 2.5 MHz at 10 Mb/s.
// (R15) Host enables recovery via PHY registers 17h then 15h.
// (R16) Host sets master/slave via PHY register 09h.
// (R17) Transmit disable high or open holds PHY in reset.
// (R18) Transmit fault pin always grounded.
// (R19) Module definition 0 grounded for presence detect.
// (R20) Host mode change: write EF, wait 10 ms, write FF, wait 20 us.
// (R21) Reads return last written value; effects apply at write end.
module mcc_top (
  input  wire logic       clock,              // 10 MHz system clock
  input  wire logic       rst_n,              // Synchronous reset, active low
  input  wire logic       scl_in,             // Serial clock pin level
  input  wire logic       sda_in,             // Serial data pin level
  output logic            sda_out,            // Serial data drive value (always 0)
  output logic            sda_oe,             // Serial data drive enable
  input  wire logic       tx_disable_in,      // Transmit disable pin, pulled up
  input  wire logic       phy_irq_n,          // PHY interrupt, active low
  input  wire logic       los_in,             // Loss of signal from PHY
  input  wire logic       clk_recov_on,       // PHY recovered clock enabled
  input  wire logic       recovered_clock_out, // PHY recovered clock, speed-dependent
  input  wire logic       local_clock_out,    // Local 25 MHz clock
  input  wire logic       link_up,            // PHY link status
  output logic            pin2_clock_out,     // Pin 2 clock output value
  output logic            pin8_out,           // Pin 8 indication
  output logic            tx_fault_out,       // Transmit fault pin (grounded)
  output logic            mod_def0_out,       // Module definition 0 (grounded)
  output logic            phy_reset_n,        // PHY reset, active low
  output logic            low_power,          // Low power mode request
  output logic            plain_gigabit_serial_mode, // Host interface select
  output logic            clk_restrict_25m,   // Restrict recovered clock to 25 MHz
  output logic            use_int_osc,        // Reference: internal oscillator
  output logic [7:0]      ctrl_byte           // Control byte readback
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_SKIP} mcc_state_e;

  mcc_state_e state_q, state_d;
  logic       scl_s, sda_s, txd_s, irq_s, los_s;
  logic       scl_p_q, sda_p_q;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] pend_q, pend_d;
  logic       pend_v_q, pend_v_d;
  logic       sda_oe_q, sda_oe_d;

  // SCL fall after the eighth rise of a byte, shared by the address and write data states
  function automatic logic byte_end(input logic fall, input logic [3:0] cnt);
    byte_end = fall && (cnt == 4'h8);
  endfunction

  // SCL, SDA, transmit disable, PHY interrupt and LOS levels pass two flops before use
  mcc_sync #(.RESET_VAL(1'b1)) u_scl (.clock(clock), .rst_n(rst_n), .d_in(scl_in),        .q_out(scl_s));
  mcc_sync #(.RESET_VAL(1'b1)) u_sda (.clock(clock), .rst_n(rst_n), .d_in(sda_in),        .q_out(sda_s));
  mcc_sync #(.RESET_VAL(1'b1)) u_txd (.clock(clock), .rst_n(rst_n), .d_in(tx_disable_in), .q_out(txd_s));
  mcc_sync #(.RESET_VAL(1'b1)) u_irq (.clock(clock), .rst_n(rst_n), .d_in(phy_irq_n),     .q_out(irq_s));
  mcc_sync #(.RESET_VAL(1'b1)) u_los (.clock(clock), .rst_n(rst_n), .d_in(los_in),        .q_out(los_s));

  // Bus events, decoded from synchronised levels only
  wire scl_rise  = scl_s & ~scl_p_q;
  wire scl_fall  = ~scl_s & scl_p_q;
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire addr_hit  = (shift_q[7:1] == mcc_pkg::MCC_ADDR_CTRL);

  // Serial slave state machine; bits sampled on SCL rise, SDA changed on SCL fall
  always_comb begin
    state_d  = state_q;
    shift_d  = shift_q;
    bit_d    = bit_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    ctrl_d   = ctrl_q;
    sda_oe_d = sda_oe_q;
    // A written byte waits for STOP, so a register address byte sent first
    // never reaches the pins; a repeated START drops it, since a pointer-only
    // write ahead of a read must not clobber the byte (limitation) [R2]
    if (stop_det && pend_v_q) begin
      ctrl_d = pend_q;                                        // [R21]
    end
    if (start_det || stop_det) begin
      pend_v_d = 1'b0;
    end
    if (start_det) begin
      state_d  = ST_ADDR;
      bit_d    = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_det) begin
      state_d  = ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = bit_q + 4'h1;
          end
          if (byte_end(scl_fall, bit_q)) begin
            if (addr_hit) begin
              state_d  = ST_ADDR_ACK;
              sda_oe_d = 1'b1;
            end else begin
              state_d = ST_SKIP;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_d   = 4'h0;
            if (shift_q[0]) begin
              state_d  = ST_RDATA;
              shift_d  = ctrl_q;                              // [R21]
              sda_oe_d = ~ctrl_q[7];
            end else begin
              state_d  = ST_WDATA;
              sda_oe_d = 1'b0;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = bit_q + 4'h1;
          end
          if (byte_end(scl_fall, bit_q)) begin
            state_d  = ST_WACK;
            sda_oe_d = 1'b1;
            // Last byte written wins; a leading register address byte is overwritten [R2]
            pend_d   = shift_q;
            pend_v_d = 1'b1;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_d  = ST_WDATA;
            bit_d    = 4'h0;
            sda_oe_d = 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              state_d  = ST_RACK;
              sda_oe_d = 1'b0;
            end else if (bit_q == 4'h0) begin
              sda_oe_d = ~shift_q[7];                        // First bit after a master ACK
            end else begin
              shift_d  = {shift_q[6:0], 1'b0};
              sda_oe_d = ~shift_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            state_d = sda_s ? ST_SKIP : ST_RDATA;             // NACK ends the read
            shift_d = ctrl_q;
            bit_d   = 4'h0;
          end
          if (scl_fall && state_q == ST_RACK) begin
            sda_oe_d = 1'b0;
          end
        end
        default: begin
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // Slave registers; control byte is 0xBF after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      shift_q  <= 8'h00;
      bit_q    <= 4'h0;
      pend_q   <= 8'h00;
      pend_v_q <= 1'b0;
      ctrl_q   <= mcc_pkg::MCC_CTRL_RESET;                     // [R1]
      sda_oe_q <= 1'b0;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      state_q  <= state_d;
      shift_q  <= shift_d;
      bit_q    <= bit_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      ctrl_q   <= ctrl_d;
      sda_oe_q <= sda_oe_d;
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
    end
  end

  // Field decode of the control byte
  wire host_plain  = ctrl_q[mcc_pkg::MCC_BIT_HOST_IF];         // [R4]
  wire lp_active   = ~ctrl_q[mcc_pkg::MCC_BIT_LOW_PWR_N];      // [R5]
  wire rst_by_reg  = ~ctrl_q[mcc_pkg::MCC_BIT_PHY_RST_N];      // [R6]
  wire restrict25  = ~ctrl_q[mcc_pkg::MCC_BIT_CLK_MODE];       // [R7]
  wire clk_out_en  = ~ctrl_q[mcc_pkg::MCC_BIT_CLK_DIS];        // [R8]
  wire pin8_is_los = ctrl_q[mcc_pkg::MCC_BIT_PIN8_LOS];        // [R9]
  wire int_osc     = ctrl_q[mcc_pkg::MCC_BIT_INT_OSC];         // [R10]
  // Either the pin or the register can hold the PHY in reset
  wire phy_rst_any = rst_by_reg | txd_s;                       // [R17]
  // Link down uses local 25 MHz, link up the PHY's recovered clock
  wire clk_src     = link_up ? recovered_clock_out : local_clock_out; // [R13] [R14]
  // Clock needs both our enable and PHY-side recovery enable
  wire clk_gate    = clk_out_en & clk_recov_on;               // [R12]
  wire pin8_d      = pin8_is_los ? los_s : irq_s;              // [R11]

  // Output flops; the pin 2 clock is resampled, so it is only useful as a
  // gated indication at 10 MHz, a trade against a combinational clock path
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin2_clock_out            <= 1'b0;
      pin8_out                  <= 1'b1;
      phy_reset_n               <= 1'b0;
      low_power                 <= 1'b0;
      plain_gigabit_serial_mode <= 1'b0;
      clk_restrict_25m          <= 1'b0;
      use_int_osc               <= 1'b1;
      ctrl_byte                 <= mcc_pkg::MCC_CTRL_RESET;
      tx_fault_out              <= 1'b0;
      mod_def0_out              <= 1'b0;
      sda_out                   <= 1'b0;
      sda_oe                    <= 1'b0;
    end else begin
      pin2_clock_out            <= clk_gate & clk_src;
      pin8_out                  <= pin8_d;
      phy_reset_n               <= ~phy_rst_any;
      low_power                 <= lp_active;
      plain_gigabit_serial_mode <= host_plain;
      clk_restrict_25m          <= restrict25;
      use_int_osc               <= int_osc;
      ctrl_byte                 <= ctrl_q;
      tx_fault_out              <= 1'b0;                       // [R18]
      mod_def0_out              <= 1'b0;                       // [R19]
      sda_out                   <= 1'b0;
      sda_oe                    <= sda_oe_q;
    end
  end

  // Checks on the decoded outputs; pins follow the byte one cycle later
  reset_value_a: assert property (@(posedge clock) $rose(rst_n) |-> ctrl_q == mcc_pkg::MCC_CTRL_RESET) // [R1]
    else $error("control byte not 0xBF after reset");
  phy_reset_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    (!ctrl_q[4] || txd_s) |=> !phy_reset_n)
    else $error("PHY reset not asserted");
  txdis_reset_a: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    (ctrl_q[4] && !txd_s) |=> phy_reset_n)
    else $error("PHY reset held without cause");
  pin8_irq_a: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
    (!ctrl_q[1] && !irq_s) |=> !pin8_out)
    else $error("pin 8 not low on PHY interrupt");
  pin8_los_a: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
    ctrl_q[1] |=> pin8_out == $past(los_s))
    else $error("pin 8 does not follow loss of signal");
  clk_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8] [R12]
    (ctrl_q[2] || !clk_recov_on) |=> !pin2_clock_out)
    else $error("pin 2 clock leaked while disabled");
  rco_link_a: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
    (!ctrl_q[2] && clk_recov_on && link_up) |=> pin2_clock_out == $past(recovered_clock_out))
    else $error("pin 2 not the recovered clock with link up");
  lco_down_a: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    (!ctrl_q[2] && clk_recov_on && !link_up) |=> pin2_clock_out == $past(local_clock_out))
    else $error("pin 2 not the local clock with link down");
  host_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    1'b1 |=> plain_gigabit_serial_mode == $past(ctrl_q[6]))
    else $error("host mode does not follow bit 6");
  low_power_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    1'b1 |=> low_power == !$past(ctrl_q[5]))
    else $error("low power does not follow bit 5");
  clk_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    1'b1 |=> clk_restrict_25m == !$past(ctrl_q[3]))
    else $error("clock mode does not follow bit 3");
  ref_clock_a: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
    1'b1 |=> use_int_osc == $past(ctrl_q[0]))
    else $error("reference select does not follow bit 0");
  fixed_pins_a: assert property (@(posedge clock) disable iff (!rst_n) // [R18] [R19]
    !tx_fault_out && !mod_def0_out)
    else $error("grounded pin driven high");

  // Checks on the bus slave and the deferred commit of a written byte
  write_apply_a: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
    (stop_det && pend_v_q) |=> ctrl_q == $past(pend_q))
    else $error("write not applied at STOP");
  ctrl_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    !stop_det |=> $stable(ctrl_q))
    else $error("control byte changed inside a transfer");
  pend_mark_a: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
    (state_q == ST_WDATA && byte_end(scl_fall, bit_q) && !start_det && !stop_det) |=> pend_v_q && pend_q == $past(shift_q))
    else $error("written byte not held for commit");
  pend_drop_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    start_det |=> !pend_v_q)
    else $error("pending byte kept across a START");
  start_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    start_det |=> state_q == ST_ADDR)
    else $error("START did not open an address phase");
  stop_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    stop_det |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("STOP did not free the bus");
  foreign_skip_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_ADDR && byte_end(scl_fall, bit_q) && !addr_hit && !start_det && !stop_det) |=> state_q == ST_SKIP)
    else $error("other address not skipped");
  ack_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_ADDR_ACK) |-> sda_oe_q)
    else $error("address not acknowledged");
  ack_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_WACK) |-> sda_oe_q)
    else $error("data byte not acknowledged");
  skip_quiet_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_SKIP || state_q == ST_IDLE) |-> !sda_oe_q)
    else $error("SDA driven outside an own transfer");
  read_load_a: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
    (state_q == ST_ADDR_ACK && scl_fall && shift_q[0] && !start_det && !stop_det) |=> shift_q == $past(ctrl_q))
    else $error("read does not load the control byte");
  read_release_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_RDATA && byte_end(scl_fall, bit_q) && !start_det && !stop_det) |=> !sda_oe_q)
    else $error("SDA not released for the master acknowledge");
  nack_end_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (state_q == ST_RACK && scl_rise && sda_s && !start_det && !stop_det) |=> state_q == ST_SKIP)
    else $error("master NACK did not end the read");
  open_drain_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    !sda_out)
    else $error("SDA drive value not low");

  write_seen_c:  cover property (@(posedge clock) state_q == ST_WACK);
  read_seen_c:   cover property (@(posedge clock) state_q == ST_RACK);
  irq_mode_c:    cover property (@(posedge clock) !ctrl_q[1] && !pin8_out);
  clk_out_c:     cover property (@(posedge clock) clk_gate && link_up);
  commit_c:      cover property (@(posedge clock) stop_det && pend_v_q);
endmodule

// ### sim/mcc_host_model.sv
// Purpose: 2-wire bus master in place of the host board controller
// Assumes: SCL and SDA pulled up; SCL high for 8 cycles and low for 10 gives an 18-cycle bit, about 555 kHz
// Notes:   Lines change just after a rising edge; SDA is held 2 cycles past every SCL fall
`timescale 1ns/100ps
module mcc_host_model (
  input  wire logic clock,    // System clock
  input  wire logic sda_line, // Resolved SDA level
  output logic      scl_out,  // SCL level, idles high
  output logic      sda_low   // High while the host pulls SDA low
);
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One bit; the hold after SCL fall avoids a false START or STOP at the slave
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    tick(8);
    scl_out <= 1'b1;
    tick(4);
    r = sda_line;
    tick(4);
    scl_out <= 1'b0;
    tick(2);
  endtask
  // Eight bits MSB first, then the acknowledge slot left released
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, nack);
  endtask
  task automatic start_c();
    sda_low <= 1'b0;
    scl_out <= 1'b1;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic stop_c();
    sda_low <= 1'b1;
    tick(8);
    scl_out <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
  endtask
  // Address, register byte, data byte; the register byte is sent as a host would
  task automatic write_ctrl(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, output logic nack);
    logic [7:0] q;
    logic       n0;
    logic       n1;
    logic       n2;
    start_c();
    byte_x({a, 1'b0}, q, n0);
    byte_x(r, q, n1);
    byte_x(d, q, n2);
    stop_c();
    nack = n0 | n1 | n2;
  endtask
  // Single-byte read ended by a master NACK
  task automatic read_ctrl(input logic [6:0] a, output logic [7:0] d, output logic nack);
    logic [7:0] q;
    logic       n;
    start_c();
    byte_x({a, 1'b1}, q, nack);
    byte_x(8'hFF, d, n);
    stop_c();
  endtask
endmodule

// ### sim/module_clock_control_bench.sv
// Purpose: Self-checking bench for the control byte slave and the pins it steers
// Assumes: Host model drives the bus; side inputs change as slow levels
// Notes:   Host waits of 10 ms and 20 us are shortened; pin 2 is checked as a resampled level
`timescale 1ns/100ps
module module_clock_control_bench;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       tx_disable_in = 1'b0;
  logic       phy_irq_n = 1'b1;
  logic       los_in = 1'b0;
  logic       clk_recov_on = 1'b0;
  logic       recovered_clock_out = 1'b0;
  logic       local_clock_out = 1'b0;
  logic       link_up = 1'b0;
  logic       scl, sda_low, sda_out, sda_oe, pin2_clock_out, pin8_out, tx_fault_out, mod_def0_out;
  logic       phy_reset_n, low_power, plain_gigabit_serial_mode, clk_restrict_25m, use_int_osc;
  logic [7:0] ctrl_byte;
  logic [7:0] exp_b;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  wire        sda = ~(sda_low | (sda_oe & ~sda_out));

  always #50 clock = ~clock;

  mcc_top DUT (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .tx_disable_in(tx_disable_in), .phy_irq_n(phy_irq_n), .los_in(los_in), .clk_recov_on(clk_recov_on),
    .recovered_clock_out(recovered_clock_out), .local_clock_out(local_clock_out), .link_up(link_up),
    .pin2_clock_out(pin2_clock_out), .pin8_out(pin8_out), .tx_fault_out(tx_fault_out),
    .mod_def0_out(mod_def0_out), .phy_reset_n(phy_reset_n), .low_power(low_power),
    .plain_gigabit_serial_mode(plain_gigabit_serial_mode), .clk_restrict_25m(clk_restrict_25m),
    .use_int_osc(use_int_osc), .ctrl_byte(ctrl_byte)
  );
  mcc_host_model host (.clock(clock), .sda_line(sda), .scl_out(scl), .sda_low(sda_low));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run needs about 21500 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      $display("MISMATCH at %0t: run did not finish", $time);
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Side inputs as one vector: tx_disable, irq_n, los, recov_on, rco, lco, link; 6 cycles cover the synchronisers
  task automatic drive(input logic [6:0] v);
    @(posedge clock);
    {tx_disable_in, phy_irq_n, los_in, clk_recov_on, recovered_clock_out, local_clock_out, link_up} <= v;
    repeat (6) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] d);
    logic nack;
    host.write_ctrl(mcc_pkg::MCC_ADDR_CTRL, ~d, d, nack);
    cmp1(nack, 1'b0, "write acknowledge");
    exp_b = d;
    repeat (4) @(posedge clock);
  endtask
  // Every output worked out from the expected byte and the side inputs, then a bus read-back
  task automatic check_all();
    logic [7:0] q;
    logic       nack;
    cmp8(ctrl_byte, exp_b, "ctrl_byte");
    cmp1(plain_gigabit_serial_mode, exp_b[6], "host mode");
    cmp1(low_power, ~exp_b[5], "low power");
    cmp1(phy_reset_n, exp_b[4] & ~tx_disable_in, "phy reset");
    cmp1(clk_restrict_25m, ~exp_b[3], "clock mode");
    cmp1(pin2_clock_out, ~exp_b[2] & clk_recov_on & (link_up ? recovered_clock_out : local_clock_out),
         "pin 2");
    cmp1(pin8_out, exp_b[1] ? los_in : phy_irq_n, "pin 8");
    cmp1(use_int_osc, exp_b[0], "ref clock");
    cmp1(tx_fault_out | mod_def0_out, 1'b0, "grounded pins");
    host.read_ctrl(mcc_pkg::MCC_ADDR_CTRL, q, nack);
    cmp1(nack, 1'b0, "read acknowledge");
    cmp8(q, exp_b, "bus read");
  endtask

  initial begin
    logic nack;
    exp_b = mcc_pkg::MCC_CTRL_RESET;
    repeat (6) @(posedge clock);
    cmp8(ctrl_byte, mcc_pkg::MCC_CTRL_RESET, "ctrl in reset");
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    check_all();
    $display("Test power-up done");
    // Interface change: assert PHY reset, then release it
    wr(8'hEF);
    check_all();
    wr(8'hFF);
    check_all();
    $display("Test host mode sequence done");
    // Bits 0 to 5 each cleared alone, bit 6 set alone, bit 7 kept at one
    for (int i = 0; i < 7; i++) begin
      wr(8'hBF ^ (8'h01 << i));
      check_all();
    end
    $display("Test bit walk done");
    wr(8'hBD);
    drive(7'b0000000);
    check_all();
    drive(7'b0100000);
    check_all();
    wr(8'hBF);
    drive(7'b0110000);
    check_all();
    $display("Test pin 8 done");
    wr(8'hBB);
    for (int j = 0; j < 16; j++) begin
      drive({3'b010, j[3:0]});
      check_all();
    end
    wr(8'hBF);
    drive(7'b0101011);
    check_all();
    $display("Test pin 2 done");
    drive(7'b1100000);
    check_all();
    drive(7'b0100000);
    check_all();
    $display("Test transmit disable done");
    // Writes meant for the PHY address are not taken by this block
    host.write_ctrl(7'h56, mcc_pkg::MCC_PHY_CR_SETUP, 8'h0F, nack);
    cmp1(nack, 1'b1, "other address");
    host.write_ctrl(7'h56, mcc_pkg::MCC_PHY_GIG_CTRL, 8'h1A, nack);
    cmp1(nack, 1'b1, "other address");
    check_all();
    $display("Test other address done");
    // A reset in mid-run brings the byte back to its power-up value
    wr(8'hA0);
    check_all();
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    exp_b = mcc_pkg::MCC_CTRL_RESET;
    repeat (8) @(posedge clock);
    check_all();
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule
